// file: common/igp_pkg.sv
/*
  Shared constants and types for the inverter gate controller: clock rate,
  switching time limits of the power module, their cycle counts, and state types.
  Assumes a single 250 MHz clock drives every module that imports it.
*/
package igp_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing limits of the power module
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS        = 4000;
  localparam int SHOOT_THROUGH_GAP_NS = 2000;  // 2.0 us between opposite switches.
  localparam int MIN_ON_WIDTH_NS      = 1000;  // 1.0 us shortest on-pulse.
  localparam int MIN_OFF_WIDTH_NS     = 2000;  // 2.0 us shortest off-interval.

  // Least times round up to whole cycles and never fall below one cycle.
  function automatic int ns_to_cyc_ceil(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int GAP_CYC  = ns_to_cyc_ceil(SHOOT_THROUGH_GAP_NS);
  localparam int ON_CYC   = ns_to_cyc_ceil(MIN_ON_WIDTH_NS);
  localparam int OFF_CYC  = ns_to_cyc_ceil(MIN_OFF_WIDTH_NS);
  localparam int IDLE_CYC = (GAP_CYC > OFF_CYC) ? GAP_CYC : OFF_CYC;

  // ----------------------------------------------------------------------
  // Counter widths and typed limits
  // ----------------------------------------------------------------------
  localparam int NUM_PHASES = 3;
  localparam int CNT_W      = 10;
  localparam int WID_W      = 20;

  typedef logic [CNT_W-1:0] igp_cnt_t;
  typedef logic [WID_W-1:0] igp_wid_t;

  localparam igp_cnt_t IDLE_CNT = igp_cnt_t'(IDLE_CYC);
  localparam igp_cnt_t ON_CNT   = igp_cnt_t'(ON_CYC);
  localparam igp_cnt_t CNT_ONE  = 10'h001;
  localparam igp_cnt_t CNT_MAX  = 10'h3FF;
  localparam igp_cnt_t CNT_ZERO = 10'h000;
  localparam igp_wid_t WID_ONE  = 20'h00001;
  localparam igp_wid_t WID_MAX  = 20'hFFFFF;
  localparam igp_wid_t WID_ZERO = 20'h00000;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {LEG_IDLE, LEG_HIGH, LEG_LOW} igp_leg_state_t;
  typedef enum logic {CTL_RUN, CTL_TRIP} igp_ctl_state_t;

endpackage

// file: core/igp_leg.sv
/*
  One inverter phase leg: turns the requested high or low gate command into
  gate drive that keeps the blocking gap, the shortest off width and, until a disable, the shortest on width, and
  needs a fresh low-to-high command after every disable.
  Assumes commands are synchronous to clk and enable comes from the controller.
*/
`timescale 1ns/10ps
module igp_leg (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic enable,
  input  wire logic cmd_high,
  input  wire logic cmd_low,
  output logic      gate_high,
  output logic      gate_low
);
  import igp_pkg::*;

  typedef struct packed {
    igp_leg_state_t st;
    igp_cnt_t       cnt;
    logic           arm_h;
    logic           arm_l;
    logic           gh;
    logic           gl;
  } igp_leg_reg_t;

  igp_leg_reg_t leg_q;
  igp_leg_reg_t leg_d;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // The disable path ignores the shortest on-width: a protection stop must win.
  always_comb begin
    leg_d = leg_q;
    leg_d.cnt = (leg_q.cnt == CNT_MAX) ? leg_q.cnt : leg_q.cnt + CNT_ONE;
    // Each input re-arms only after it has been seen low while enabled.
    if (!enable) begin
      leg_d.arm_h = 1'b0; // R15
      leg_d.arm_l = 1'b0; // R15
    end else begin
      if (!cmd_high) leg_d.arm_h = 1'b1; // R8
      if (!cmd_low) leg_d.arm_l = 1'b1; // R3 R6
    end
    case (leg_q.st)
      LEG_IDLE: begin
        if (enable && leg_q.cnt >= IDLE_CNT) begin // R9 R11
          if (cmd_high && !cmd_low && leg_q.arm_h) begin
            leg_d.st  = LEG_HIGH;
            leg_d.cnt = CNT_ZERO;
          end else if (cmd_low && !cmd_high && leg_q.arm_l) begin
            leg_d.st  = LEG_LOW;
            leg_d.cnt = CNT_ZERO;
          end
        end
      end
      LEG_HIGH: begin
        if (!enable || (!cmd_high && leg_q.cnt >= ON_CNT)) begin // R10
          leg_d.st  = LEG_IDLE;
          leg_d.cnt = CNT_ZERO;
        end
      end
      LEG_LOW: begin
        if (!enable || (!cmd_low && leg_q.cnt >= ON_CNT)) begin // R10
          leg_d.st  = LEG_IDLE;
          leg_d.cnt = CNT_ZERO;
        end
      end
      default: begin
        leg_d.st  = LEG_IDLE;
        leg_d.cnt = CNT_ZERO;
      end
    endcase
    leg_d.gh = (leg_d.st == LEG_HIGH);
    leg_d.gl = (leg_d.st == LEG_LOW);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Counter starts at zero so the first turn-on also waits a full gap.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      leg_q <= '{st: LEG_IDLE, cnt: CNT_ZERO, arm_h: 1'b0, arm_l: 1'b0, gh: 1'b0, gl: 1'b0};
    end else begin
      leg_q <= leg_d;
    end
  end

  assign gate_high = leg_q.gh;
  assign gate_low  = leg_q.gl;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  int off_run_q;
  int on_run_q;
  localparam int IDLE_CYC_L = IDLE_CYC;
  localparam int ON_CYC_L   = ON_CYC;

  // Independent run-length counters of the pins, read only by the checks.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      off_run_q <= 0;
      on_run_q  <= 0;
    end else begin
      off_run_q <= (gate_high || gate_low) ? 0 : ((off_run_q > 4000) ? off_run_q : off_run_q + 1);
      on_run_q  <= (gate_high || gate_low) ? ((on_run_q > 4000) ? on_run_q : on_run_q + 1) : 0;
    end
  end

  a_no_cross: assert property (@(posedge clk) disable iff (!rstn) // R9
    !(gate_high && gate_low)) else $error("both gates of one leg on");

  a_gap_before_on: assert property (@(posedge clk) disable iff (!rstn) // R9
    ($rose(gate_high) || $rose(gate_low)) |-> $past(off_run_q) >= IDLE_CYC_L)
    else $error("gate turned on before the blocking gap elapsed");

  a_min_on_width: assert property (@(posedge clk) disable iff (!rstn) // R10
    ($fell(gate_high) || $fell(gate_low)) && $past(enable) |-> $past(on_run_q) >= ON_CYC_L)
    else $error("on-pulse shorter than the shortest on-width");

  a_disable_off: assert property (@(posedge clk) disable iff (!rstn) // R11
    !enable |=> !gate_high && !gate_low) else $error("gate still on after disable");

  a_fresh_edge: assert property (@(posedge clk) disable iff (!rstn) // R15
    $rose(gate_high) |-> $past(leg_q.arm_h) && $past(cmd_high))
    else $error("high gate turned on without a fresh command edge");
endmodule

// file: core/igp_ctrl.sv
/*
  Host-side gate controller for a three-phase inverter power module. It drives
  the six high-active gate inputs, feeds the short-circuit sense input from
  three shunt comparators, watches the open-drain fault line, and stops all
  switching on a fault or on the host's own thermal limit.
  Assumes the fault line has an external pull-up, all inputs are synchronous
  to clk, and the module's own protection acts on its pins as described below.
  Limitation: the host cannot see a bootstrap supply dip, so a high side may
  stay commanded while the module holds it off; the width output is the only
  way to tell a short trip from a long undervoltage dip.
*/
// Behaviour
// R1 - Module forces all low sides off on short.
// R2 - Module holds fault line for capacitor-set width.
// R3 - After short, low side needs new rising edge.
// R4 - Module blocks low sides on supply undervoltage.
// R5 - Undervoltage fault lasts while supply stays low.
// R6 - After supply recovery, low side needs rising edge.
// R7 - Boot undervoltage blocks one high side, silently.
// R8 - After boot recovery, high side needs rising edge.
// R9 - Keep both leg inputs off for blocking gap.
// R10 - Never issue on-pulses shorter than 1.0 us; a disable still cuts an on-pulse short.
// R11 - Keep off-intervals at least 2.0 us long.
// R12 - Fault line is open drain; pull-up outside.
// R13 - OR shunt comparators into sense input quickly.
// R14 - Fault never flags heat; host stops itself.
// R15 - Each input re-arms on fresh edge after trip.
`timescale 1ns/10ps
module igp_ctrl (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic                           run_en,
  input  wire logic [igp_pkg::NUM_PHASES-1:0] cmd_high,
  input  wire logic [igp_pkg::NUM_PHASES-1:0] cmd_low,
  input  wire logic [igp_pkg::NUM_PHASES-1:0] shunt_trip,
  input  wire logic                           over_temp,
  input  wire logic                           fault_out_n,
  output logic                                phase_a_high_in,
  output logic                                phase_b_high_in,
  output logic                                phase_c_high_in,
  output logic                                phase_a_low_in,
  output logic                                phase_b_low_in,
  output logic                                phase_c_low_in,
  output logic                                short_sense_in,
  output logic                                tripped,
  output logic                                fault_active,
  output igp_pkg::igp_wid_t                   fault_pulse_width
);
  import igp_pkg::*;

  typedef struct packed {
    igp_ctl_state_t st;
    logic           sense;
    logic           fault;
    igp_wid_t       wcnt;
    igp_wid_t       wlast;
  } igp_ctl_reg_t;

  igp_ctl_reg_t ctl_q;
  igp_ctl_reg_t ctl_d;

  logic                  leg_en;
  logic [NUM_PHASES-1:0] gate_high;
  logic [NUM_PHASES-1:0] gate_low;

  // ----------------------------------------------------------------------
  // Leg enable
  // ----------------------------------------------------------------------
  // The raw fault pin gates the legs directly so the stop costs one cycle,
  // not two; the pin is taken as synchronous, so no metastability path.
  assign leg_en = run_en && (ctl_q.st == CTL_RUN) && fault_out_n && !over_temp; // R12 R14

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    ctl_d = ctl_q;
    // Registered OR of the shunt comparators; one cycle keeps well under 2 us.
    ctl_d.sense = |shunt_trip; // R13
    ctl_d.fault = !fault_out_n;
    case (ctl_q.st)
      CTL_RUN: begin
        // A low fault line means short or low-side undervoltage inside.
        if (!fault_out_n || over_temp || ctl_q.sense) begin // R1 R4 R14
          ctl_d.st = CTL_TRIP;
        end
      end
      CTL_TRIP: begin
        // Stay stopped while the module stretches its fault pulse.
        if (fault_out_n && !over_temp && !ctl_q.sense) begin // R2 R5
          ctl_d.st = CTL_RUN;
        end
      end
      default: begin
        ctl_d.st = CTL_TRIP;
      end
    endcase
    // Measure each fault pulse; the width tells short trips from undervoltage.
    if (!fault_out_n) begin
      ctl_d.wcnt = (ctl_q.wcnt == WID_MAX) ? ctl_q.wcnt : ctl_q.wcnt + WID_ONE;
    end else if (ctl_q.fault) begin
      ctl_d.wlast = ctl_q.wcnt;
      ctl_d.wcnt  = WID_ZERO;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset lands in the tripped state so switching starts only once the
  // fault line is seen released after power-up.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= '{st: CTL_TRIP, sense: 1'b0, fault: 1'b0, wcnt: WID_ZERO, wlast: WID_ZERO};
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Phase legs
  // ----------------------------------------------------------------------
  // Boot supply faults are invisible here; the fresh-edge re-arm in each leg
  // acts only after a disable, so it gives no fresh edge after the module recovers on its own.
  genvar p;
  generate
    for (p = 0; p < NUM_PHASES; p++) begin : g_leg
      igp_leg u_leg (
        .clk       (clk),
        .rstn      (rstn),
        .enable    (leg_en),
        .cmd_high  (cmd_high[p]),
        .cmd_low   (cmd_low[p]),
        .gate_high (gate_high[p]),
        .gate_low  (gate_low[p])
      ); // R7 R8
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Gate pins come straight from leg flip-flops, so no glitch reaches the
  // module even while the next-state logic settles.
  assign phase_a_high_in   = gate_high[0];
  assign phase_b_high_in   = gate_high[1];
  assign phase_c_high_in   = gate_high[2];
  assign phase_a_low_in    = gate_low[0];
  assign phase_b_low_in    = gate_low[1];
  assign phase_c_low_in    = gate_low[2];
  assign short_sense_in    = ctl_q.sense;
  assign tripped           = (ctl_q.st == CTL_TRIP);
  assign fault_active      = ctl_q.fault;
  assign fault_pulse_width = ctl_q.wlast;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // The properties below watch the pins as the module sees them; they run
  // on the one clock and are all silenced while reset is held.
  sequence s_fault_seen;
    !fault_out_n;
  endsequence

  sequence s_all_off;
    (gate_high == 3'h0) && (gate_low == 3'h0);
  endsequence

  a_fault_stops_all: assert property (@(posedge clk) disable iff (!rstn) // R1
    s_fault_seen |=> s_all_off) else $error("gates on after fault line went low");

  a_trip_holds: assert property (@(posedge clk) disable iff (!rstn) // R5
    tripped && !fault_out_n |=> tripped) else $error("left trip while fault line low");

  a_heat_stops_all: assert property (@(posedge clk) disable iff (!rstn) // R14
    over_temp |=> s_all_off ##0 tripped) else $error("switching continued over thermal limit");

  a_sense_follows: assert property (@(posedge clk) disable iff (!rstn) // R13
    (|shunt_trip) |=> short_sense_in ##1 tripped) else $error("shunt trip not passed to sense");

  a_width_latched: assert property (@(posedge clk) disable iff (!rstn) // R2
    $rose(fault_out_n) && $past(ctl_q.wcnt) != WID_MAX |=>
      fault_pulse_width == $past(ctl_q.wcnt))
    else $error("fault pulse width not captured");

  a_trip_releases: assert property (@(posedge clk) disable iff (!rstn) // R3
    tripped && fault_out_n && !over_temp && !short_sense_in |=> !tripped)
    else $error("trip not released after fault cleared");

  // A stopped controller must hold every gate low from the next edge on;
  // the one-cycle lag covers a trip raised by the registered sense path.
  sequence s_stopped;
    tripped;
  endsequence

  a_trip_gates_off: assert property (@(posedge clk) disable iff (!rstn) // R1
    s_stopped |=> s_all_off) else $error("gate on while controller stopped");

  // The sense line must drop again once no comparator reports a short,
  // or the module would keep stretching its fault pulse.
  sequence s_no_shunt;
    shunt_trip == 3'h0;
  endsequence

  a_sense_clears: assert property (@(posedge clk) disable iff (!rstn) // R13
    s_no_shunt |=> !short_sense_in) else $error("sense held without a shunt trip");

  // The fault flag is a one-cycle delayed, inverted copy of the pin.
  a_fault_mirror: assert property (@(posedge clk) disable iff (!rstn) // R12
    s_fault_seen |=> fault_active) else $error("fault flag missed a low fault line");

  a_fault_drops: assert property (@(posedge clk) disable iff (!rstn) // R12
    fault_out_n |=> !fault_active) else $error("fault flag set with the line high");

  // While the line is low the width counter advances by one each cycle,
  // until it saturates, so long undervoltage dips read as full scale.
  a_width_counts: assert property (@(posedge clk) disable iff (!rstn) // R5
    !fault_out_n && ctl_q.wcnt != WID_MAX |=> ctl_q.wcnt == $past(ctl_q.wcnt) + WID_ONE)
    else $error("fault width counter did not advance");

  // Taking away the host's permission stops switching at the next edge.
  a_run_gates: assert property (@(posedge clk) disable iff (!rstn) // R11
    !run_en |=> s_all_off) else $error("gate on after run permission dropped");

  // No phase may drive both switches in the same cycle.
  a_legs_exclusive: assert property (@(posedge clk) disable iff (!rstn) // R9
    (gate_high & gate_low) == 3'h0) else $error("both switches of a phase on");
endmodule

// file: verif/igp_module_model.sv
/*
  Behavioural model of the three-phase power module that the controller drives:
  low-side and high-side protection, per-input re-arm and the open-drain fault line.
  Assumes the bench supplies the fault line pull-up and the undervoltage controls.
*/
`timescale 1ns/10ps
module igp_module_model #(
  parameter int FO_CYC = 40
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] high_in,
  input  wire logic [2:0] low_in,
  input  wire logic       short_sense_in,
  input  wire logic       low_uv,
  input  wire logic [2:0] boot_uv,
  output logic            fault_oe_n
);
  // ----------------------------------------------------------------------
  // Protection state
  // ----------------------------------------------------------------------
  logic [15:0] fo_cnt_q;
  logic [2:0]  arm_l_q;
  logic [2:0]  arm_h_q;
  logic [2:0]  sw_l_q;
  logic [2:0]  sw_h_q;
  logic        trip_l;

  // Short circuit and low supply undervoltage share the low-side trip.
  assign trip_l = short_sense_in | low_uv;

  // The fault line is pulled low only while the width count runs; heat never counts.
  assign fault_oe_n = (fo_cnt_q == 16'h0000);

  // Each input re-arms only when seen low after its fault has cleared.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fo_cnt_q <= 16'h0000;
      arm_l_q  <= 3'h0;
      arm_h_q  <= 3'h0;
      sw_l_q   <= 3'h0;
      sw_h_q   <= 3'h0;
    end else begin
      if (trip_l) begin
        fo_cnt_q <= 16'(FO_CYC);
      end else if (fo_cnt_q != 16'h0000) begin
        fo_cnt_q <= fo_cnt_q - 16'h0001;
      end
      for (int i = 0; i < 3; i++) begin
        if (trip_l) begin
          arm_l_q[i] <= 1'b0;
        end else if (fo_cnt_q == 16'h0000 && !low_in[i]) begin
          arm_l_q[i] <= 1'b1;
        end
        if (boot_uv[i]) begin
          arm_h_q[i] <= 1'b0;
        end else if (!high_in[i]) begin
          arm_h_q[i] <= 1'b1;
        end
        sw_l_q[i] <= !trip_l & arm_l_q[i] & low_in[i];
        sw_h_q[i] <= !boot_uv[i] & arm_h_q[i] & high_in[i];
      end
    end
  end
endmodule

// file: verif/igp_ctrl_bench.sv
/*
  Self-checking bench for the gate controller against the power module model.
  Assumes a 250 MHz clock, inputs driven at the falling edge, one fault pull-up.
*/
`timescale 1ns/10ps
module igp_ctrl_bench;
  import igp_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam int FO_CYC = 40;
  logic                 clk;
  logic                 rstn;
  logic                 run_en;
  logic [2:0]           cmd_high;
  logic [2:0]           cmd_low;
  logic [2:0]           shunt_trip;
  logic                 over_temp;
  logic                 low_uv;
  logic [2:0]           boot_uv;
  logic                 fault_oe_n;
  logic                 fault_out_n;
  logic [2:0]           hin;
  logic [2:0]           lin;
  logic                 sense;
  logic                 tripped;
  logic                 fault_active;
  igp_wid_t             fault_pulse_width;
  logic [7:0]           mon;
  int                   fails;
  int                   checked;
  int                   n;

  // The pull-up holds the line high whenever the module lets go of it.
  assign fault_out_n = fault_oe_n ? 1'b1 : 1'b0;
  assign mon = {fault_active, tripped, hin, lin};

  igp_ctrl dut_u (.clk(clk), .rstn(rstn), .run_en(run_en), .cmd_high(cmd_high),
    .cmd_low(cmd_low), .shunt_trip(shunt_trip), .over_temp(over_temp),
    .fault_out_n(fault_out_n), .phase_a_high_in(hin[0]), .phase_b_high_in(hin[1]),
    .phase_c_high_in(hin[2]), .phase_a_low_in(lin[0]), .phase_b_low_in(lin[1]),
    .phase_c_low_in(lin[2]), .short_sense_in(sense), .tripped(tripped),
    .fault_active(fault_active), .fault_pulse_width(fault_pulse_width));

  igp_module_model #(.FO_CYC(FO_CYC)) model_u (.clk(clk), .rstn(rstn), .high_in(hin),
    .low_in(lin), .short_sense_in(sense), .low_uv(low_uv), .boot_uv(boot_uv),
    .fault_oe_n(fault_oe_n));

  always #2 clk = ~clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits for one monitored bit to take a level; a spent bound ends the run.
  task automatic wait_bit(input int b, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (mon[b] !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (cnt >= lim) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, mon[b], v);
      results();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // An early release of the low command must still give the full on-width.
  task automatic t_pulse();
    cmd_low[0] = 1'b1;
    wait_bit(0, 1'b1, 1200, n);
    cmd_low[0] = 1'b0;
    cmd_high[0] = 1'b1;
    wait_bit(0, 1'b0, 600, n);
    check(n >= ON_CYC, 1);
    wait_bit(3, 1'b1, 1200, n);
    check(n >= IDLE_CYC, 1);
    check(lin[0], 0);
    cmd_high[0] = 1'b0;
    wait_bit(3, 1'b0, 600, n);
  endtask

  // Asking for both switches of one leg must give neither.
  task automatic t_both();
    logic acc;
    acc = 1'b0;
    cmd_high[1] = 1'b1;
    cmd_low[1] = 1'b1;
    repeat (700) begin
      @(negedge clk);
      acc = acc | hin[1] | lin[1];
    end
    check(acc, 0);
    cmd_high[1] = 1'b0;
    cmd_low[1] = 1'b0;
  endtask

  // A one-cycle shunt trip stops the leg; a held command may not restart it.
  task automatic t_short();
    cmd_low[0] = 1'b1;
    wait_bit(0, 1'b1, 1200, n);
    shunt_trip[2] = 1'b1;
    @(negedge clk);
    shunt_trip[2] = 1'b0;
    check(sense, 1);
    repeat (2) @(negedge clk);
    check({tripped, fault_active, lin[0]}, 3'h6);
    wait_bit(7, 1'b0, 4 * FO_CYC, n);
    check(fault_pulse_width, FO_CYC);
    repeat (700) @(negedge clk);
    check(lin[0], 0);
    cmd_low[0] = 1'b0;
    repeat (2) @(negedge clk);
    cmd_low[0] = 1'b1;
    wait_bit(0, 1'b1, 1200, n);
    cmd_low[0] = 1'b0;
    wait_bit(0, 1'b0, 600, n);
  endtask

  // A long supply dip stretches the fault beyond the capacitor width.
  task automatic t_uv();
    low_uv = 1'b1;
    repeat (100) @(negedge clk);
    check(tripped, 1);
    low_uv = 1'b0;
    wait_bit(7, 1'b0, 4 * FO_CYC, n);
    check(fault_pulse_width, FO_CYC + 99);
  endtask

  // A bootstrap dip is silent on the fault line.
  task automatic t_boot();
    // The command must be seen low on an enabled edge before it can arm.
    repeat (2) @(negedge clk);
    cmd_high[1] = 1'b1;
    wait_bit(4, 1'b1, 1200, n);
    boot_uv[1] = 1'b1;
    repeat (50) @(negedge clk);
    check({tripped, fault_active}, 2'h0);
    boot_uv[1] = 1'b0;
    cmd_high[1] = 1'b0;
    wait_bit(4, 1'b0, 600, n);
  endtask

  // The host thermal limit stops switching without any fault from the module.
  task automatic t_heat();
    cmd_low[2] = 1'b1;
    wait_bit(2, 1'b1, 1200, n);
    over_temp = 1'b1;
    repeat (2) @(negedge clk);
    check({tripped, fault_active, hin[2], lin[2]}, 4'h8);
    over_temp = 1'b0;
    cmd_low[2] = 1'b0;
    repeat (20) @(negedge clk);
    cmd_low[2] = 1'b1;
    wait_bit(2, 1'b1, 1200, n);
    run_en = 1'b0;
    repeat (2) @(negedge clk);
    check({tripped, lin[2]}, 2'h0);
    run_en = 1'b1;
    cmd_low[2] = 1'b0;
    repeat (20) @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    run_en = 1'b1;
    cmd_high = 3'h0;
    cmd_low = 3'h0;
    shunt_trip = 3'h0;
    over_temp = 1'b0;
    low_uv = 1'b0;
    boot_uv = 3'h0;
    fails = 0;
    checked = 0;
    repeat (12) @(negedge clk);
    check({tripped, hin, lin, sense}, 8'h80);
    rstn = 1'b1;
    // Commands stay low until the first enabled edge so every input can arm.
    repeat (2) @(negedge clk);
    t_pulse();
    t_both();
    t_short();
    t_uv();
    t_boot();
    t_heat();
    results();
  end
endmodule
